// ### rtl/dacrb_pkg.sv
// Constants and types of the DAC I2C readback engine.
// Assumes a core clock of 10 MHz and an I2C master that drives SCL.
package dacrb_pkg;

  // ****************************************
  // Bus format
  // ****************************************
  localparam logic [2:0] ADDR_FIXED = 3'h1;
  localparam int         BYTE_W     = 8;
  localparam logic [3:0] BIT_LAST   = 4'h8;
  localparam logic [7:0] FILL_BYTE  = 8'hff;

  // ****************************************
  // Readback words
  // ****************************************
  localparam int         VAL_W          = 12;
  localparam int         CH_NUM         = 4;
  localparam logic [3:0] VAL_PAD        = 4'h0;
  localparam logic [3:0] NIB_STAGED     = 4'h0;
  localparam logic [3:0] NIB_LOAD_FIRST = 4'h1;
  localparam logic [3:0] NIB_LOAD_LAST  = 4'h3;
  localparam logic [3:0] NIB_POWER      = 4'h4;
  localparam logic [3:0] SEL_LAST_CH    = 4'h3;
  localparam logic [2:0] ID_ZEROS       = 3'h0;
  localparam logic [11:0] PWR_ZEROS     = 12'h000;
  localparam logic [1:0] CH_A           = 2'h0;
  localparam logic [7:0] CMD_ALL_STAGED = 8'h80;
  localparam logic [7:0] CMD_ALL_ACT_LO = 8'h81;
  localparam logic [7:0] CMD_ALL_ACT_HI = 8'h83;

  // ****************************************
  // Byte positions and write lengths
  // ****************************************
  localparam logic [1:0] IDX_FIRST  = 2'h0;
  localparam logic [1:0] IDX_SECOND = 2'h1;
  localparam logic [1:0] IDX_THIRD  = 2'h2;
  localparam logic [1:0] IDX_SAT    = 2'h3;
  localparam logic [1:0] LEN_COMB   = 2'h1;
  localparam logic       MODE_COMB  = 1'b0;
  localparam logic       MODE_VERIF = 1'b1;
  localparam int         FIFO_DEPTH = 8;

  // ****************************************
  // Slave state machine
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACKW = 6'h04,
    ST_TX   = 6'h08,
    ST_MACK = 6'h10,
    ST_IGN  = 6'h20
  } dacrb_state_t;

endpackage

// ### rtl/dacrb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module dacrb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // ****************************************
  // Pointer arithmetic
  // ****************************************
  always_comb begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // dacrb_fifo

// ### rtl/dacrb_engine.sv
// I2C slave readback engine of a quad-channel DAC.
// Assumes scl_in and scl_clk carry the same SCL wire; SDA is open drain.
`timescale 1ns/100ps
module dacrb_engine #(
  parameter logic [7:0] IDENT_BYTE = 8'h5a, // Arbitrary identity value
  parameter logic [2:0] REVISION   = 3'h1   // Arbitrary revision value
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  scl_clk,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  input  wire logic [1:0]            address_strap_low,
  input  wire logic [1:0]            address_strap_high,
  input  wire logic [3:0][11:0]      staged_code_value,
  input  wire logic [3:0][11:0]      active_output_value,
  input  wire logic                  chan_a_powerdown_flag,
  input  wire logic                  chan_b_powerdown_flag,
  input  wire logic                  chan_c_powerdown_flag,
  input  wire logic                  chan_d_powerdown_flag,
  input  wire logic [1:0]            reference_mode_field,
  output logic [7:0]                 wr_data,
  output logic                       wr_valid,
  input  wire logic                  wr_ready,
  output logic                       readback_mode
);

  // ****************************************
  // Link domain: samples SDA on each SCL rise
  // ****************************************
  logic link_clr;
  logic link_tog;
  logic link_bit;
  logic next_link_tog;

  assign next_link_tog = ~link_tog;

  always_ff @(posedge scl_clk or posedge link_clr) begin
    if (link_clr) begin
      link_tog <= 1'b0;
      link_bit <= 1'b0;
    end else begin
      link_tog <= next_link_tog;
      link_bit <= sda_in;
    end
  end

  // ****************************************
  // Synchronisers into the core domain
  // ****************************************
  logic [1:0] pin_s1, pin_s2, pin_s3;
  logic [3:0] strap_s1, strap_s2;
  logic       tog_s1, tog_s2, tog_s3, tog_s4;
  logic       bit_s1, bit_s2;

  always_ff @(posedge core_clk) begin
    link_clr <= rst;
    pin_s1   <= {scl_in, sda_in};
    pin_s2   <= pin_s1;
    pin_s3   <= pin_s2;
    strap_s1 <= {address_strap_high, address_strap_low};
    strap_s2 <= strap_s1;
    tog_s1   <= link_tog;
    tog_s2   <= tog_s1;
    tog_s3   <= tog_s2;
    tog_s4   <= tog_s3;
    bit_s1   <= link_bit;
    bit_s2   <= bit_s1;
  end

  logic rise_ev, fall_ev, start_det, stop_det;
  assign rise_ev   = tog_s3 ^ tog_s4;
  assign fall_ev   = pin_s3[1] && !pin_s2[1];
  assign start_det = pin_s2[1] && pin_s3[1] && pin_s3[0] && !pin_s2[0];
  assign stop_det  = pin_s2[1] && pin_s3[1] && !pin_s3[0] && pin_s2[0];

  // ****************************************
  // Readback word
  // ****************************************
  function automatic logic [1:0] pick_ch(input logic [3:0] sel);
    pick_ch = (sel > dacrb_pkg::SEL_LAST_CH) ? dacrb_pkg::CH_A : sel[1:0];
  endfunction

  logic [7:0]  req_cmd;
  logic [15:0] rd_word;
  logic [1:0]  ch;

  always_comb begin
    ch = pick_ch(req_cmd[3:0]);
    if (req_cmd == dacrb_pkg::CMD_ALL_STAGED) begin
      rd_word = {staged_code_value[dacrb_pkg::CH_A],
                 dacrb_pkg::VAL_PAD};
    end else if (req_cmd >= dacrb_pkg::CMD_ALL_ACT_LO &&
                 req_cmd <= dacrb_pkg::CMD_ALL_ACT_HI) begin
      rd_word = {active_output_value[dacrb_pkg::CH_A],
                 dacrb_pkg::VAL_PAD};
    end else if (req_cmd[7:4] == dacrb_pkg::NIB_STAGED) begin
      rd_word = {staged_code_value[ch], dacrb_pkg::VAL_PAD};
    end else if (req_cmd[7:4] >= dacrb_pkg::NIB_LOAD_FIRST &&
                 req_cmd[7:4] <= dacrb_pkg::NIB_LOAD_LAST) begin
      rd_word = {active_output_value[ch], dacrb_pkg::VAL_PAD};
    end else if (req_cmd[7:4] == dacrb_pkg::NIB_POWER) begin
      rd_word = {dacrb_pkg::PWR_ZEROS, chan_d_powerdown_flag,
                 chan_c_powerdown_flag, chan_b_powerdown_flag,
                 chan_a_powerdown_flag};
    end else begin
      rd_word = {IDENT_BYTE, dacrb_pkg::ID_ZEROS, REVISION,
                 reference_mode_field};
    end
  end

  // ****************************************
  // Slave state machine
  // ****************************************
  dacrb_pkg::dacrb_state_t state, next_state;
  logic [3:0]  bitn, next_bitn;
  logic [7:0]  shreg, next_shreg;
  logic [7:0]  txsh, next_txsh;
  logic [7:0]  tx_byte, next_tx_byte;
  logic        addr_ph, next_addr_ph;
  logic        is_rd, next_is_rd;
  logic        in_wr, next_in_wr;
  logic        ack, next_ack;
  logic        mack, next_mack;
  logic [1:0]  wr_cnt, next_wr_cnt;
  logic [1:0]  wr_tot, next_wr_tot;
  logic        wr_exec, next_wr_exec;
  logic [7:0]  cmd_hold, next_cmd_hold;
  logic [7:0]  hi_hold, next_hi_hold;
  logic [23:0] last_cmd, next_last_cmd;
  logic [7:0]  next_req_cmd;
  logic        next_mode;
  logic        consumed, next_consumed;
  logic [1:0]  byte_idx, next_byte_idx;
  logic        next_sda_oe_n;
  logic        push_valid, push_ready;
  logic        frame_end;

  function automatic logic [7:0] pick_byte(input logic       md,
                                           input logic       used,
                                           input logic [1:0] idx,
                                           input logic [15:0] wd,
                                           input logic [23:0] lc);
    pick_byte = dacrb_pkg::FILL_BYTE;
    if (md == dacrb_pkg::MODE_VERIF) begin
      if (!used && idx == dacrb_pkg::IDX_FIRST) pick_byte = lc[23:16];
      if (!used && idx == dacrb_pkg::IDX_SECOND) pick_byte = lc[15:8];
      if (!used && idx == dacrb_pkg::IDX_THIRD) pick_byte = lc[7:0];
    end else begin
      if (idx == dacrb_pkg::IDX_FIRST) pick_byte = wd[15:8];
      if (idx == dacrb_pkg::IDX_SECOND) pick_byte = wd[7:0];
    end
  endfunction

  assign frame_end = start_det || stop_det;

  always_comb begin
    next_state    = state;
    next_bitn     = bitn;
    next_shreg    = shreg;
    next_txsh     = txsh;
    next_tx_byte  = tx_byte;
    next_addr_ph  = addr_ph;
    next_is_rd    = is_rd;
    next_in_wr    = in_wr;
    next_ack      = ack;
    next_mack     = mack;
    next_wr_cnt   = wr_cnt;
    next_wr_tot   = wr_tot;
    next_wr_exec  = wr_exec;
    next_cmd_hold = cmd_hold;
    next_hi_hold  = hi_hold;
    next_last_cmd = last_cmd;
    next_req_cmd  = req_cmd;
    next_mode     = readback_mode;
    next_consumed = consumed;
    next_byte_idx = byte_idx;
    next_sda_oe_n = sda_oe_n;
    push_valid    = 1'b0;
    if (frame_end) begin
      if (in_wr && wr_tot == dacrb_pkg::LEN_COMB && !wr_exec) begin
        next_mode    = dacrb_pkg::MODE_COMB;
        next_req_cmd = cmd_hold;
      end else if (in_wr && wr_exec) begin
        next_mode     = dacrb_pkg::MODE_VERIF;
        next_consumed = 1'b0;
      end
      if (is_rd && readback_mode == dacrb_pkg::MODE_VERIF) begin
        next_consumed = 1'b1;
      end
      next_in_wr    = 1'b0;
      next_is_rd    = 1'b0;
      next_sda_oe_n = 1'b1;
      next_bitn     = '0;
      next_addr_ph  = 1'b1;
      next_state    = start_det ? dacrb_pkg::ST_RX
                                : dacrb_pkg::ST_IDLE;
    end else begin
      case (state)
        dacrb_pkg::ST_IDLE, dacrb_pkg::ST_IGN: begin
          next_sda_oe_n = 1'b1;
        end
        dacrb_pkg::ST_RX: begin
          if (rise_ev) begin
            next_shreg = {shreg[6:0], bit_s2};
            next_bitn  = bitn + 4'h1;
          end else if (fall_ev && bitn == dacrb_pkg::BIT_LAST) begin
            next_bitn = '0;
            next_ack  = 1'b0;
            if (addr_ph) begin
              if (shreg[7:1] == {dacrb_pkg::ADDR_FIXED, strap_s2}) begin
                next_ack      = 1'b1;
                next_is_rd    = shreg[0];
                next_in_wr    = !shreg[0];
                next_wr_cnt   = dacrb_pkg::IDX_FIRST;
                next_wr_tot   = dacrb_pkg::IDX_FIRST;
                next_wr_exec  = 1'b0;
                next_byte_idx = dacrb_pkg::IDX_FIRST;
              end
            end else if (push_ready) begin
              next_ack   = 1'b1;
              push_valid = 1'b1;
              if (wr_tot != dacrb_pkg::IDX_SAT) begin
                next_wr_tot = wr_tot + 2'h1;
              end
              next_wr_cnt = (wr_cnt == dacrb_pkg::IDX_THIRD) ?
                            dacrb_pkg::IDX_FIRST : wr_cnt + 2'h1;
              if (wr_cnt == dacrb_pkg::IDX_FIRST) next_cmd_hold = shreg;
              if (wr_cnt == dacrb_pkg::IDX_SECOND) next_hi_hold = shreg;
              if (wr_cnt == dacrb_pkg::IDX_THIRD) begin
                next_last_cmd = {cmd_hold, hi_hold, shreg};
                next_wr_exec  = 1'b1;
              end
            end
            next_sda_oe_n = !next_ack;
            next_state    = next_ack ? dacrb_pkg::ST_ACKW
                                     : dacrb_pkg::ST_IGN;
          end
        end
        dacrb_pkg::ST_ACKW: begin
          if (fall_ev) begin
            next_addr_ph = 1'b0;
            if (is_rd) begin
              next_tx_byte  = pick_byte(readback_mode, consumed, byte_idx,
                                        rd_word, last_cmd);
              next_sda_oe_n = next_tx_byte[7];
              next_txsh     = {next_tx_byte[6:0], 1'b0};
              next_byte_idx = byte_idx + 2'h1;
              next_state    = dacrb_pkg::ST_TX;
            end else begin
              next_sda_oe_n = 1'b1;
              next_state    = dacrb_pkg::ST_RX;
            end
          end
        end
        dacrb_pkg::ST_TX: begin
          if (rise_ev) begin
            next_bitn = bitn + 4'h1;
          end else if (fall_ev) begin
            if (bitn == dacrb_pkg::BIT_LAST) begin
              next_sda_oe_n = 1'b1;
              next_bitn     = '0;
              next_state    = dacrb_pkg::ST_MACK;
            end else begin
              next_sda_oe_n = txsh[7];
              next_txsh     = {txsh[6:0], 1'b0};
            end
          end
        end
        dacrb_pkg::ST_MACK: begin
          if (rise_ev) begin
            next_mack = !bit_s2;
          end else if (fall_ev) begin
            if (mack) begin
              next_tx_byte  = pick_byte(readback_mode, consumed, byte_idx,
                                        rd_word, last_cmd);
              next_sda_oe_n = next_tx_byte[7];
              next_txsh     = {next_tx_byte[6:0], 1'b0};
              if (byte_idx != dacrb_pkg::IDX_SAT) begin
                next_byte_idx = byte_idx + 2'h1;
              end
              next_state    = dacrb_pkg::ST_TX;
            end else begin
              next_state = dacrb_pkg::ST_IGN;
            end
          end
        end
        default: begin
          next_state = dacrb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state         <= dacrb_pkg::ST_IDLE;
      bitn          <= '0;
      shreg         <= '0;
      txsh          <= '0;
      tx_byte       <= '0;
      addr_ph       <= 1'b1;
      is_rd         <= 1'b0;
      in_wr         <= 1'b0;
      ack           <= 1'b0;
      mack          <= 1'b0;
      wr_cnt        <= '0;
      wr_tot        <= '0;
      wr_exec       <= 1'b0;
      cmd_hold      <= '0;
      hi_hold       <= '0;
      last_cmd      <= '0;
      req_cmd       <= '0;
      readback_mode <= dacrb_pkg::MODE_COMB;
      consumed      <= 1'b1;
      byte_idx      <= '0;
      sda_oe_n      <= 1'b1;
      sda_out       <= 1'b0;
    end else begin
      state         <= next_state;
      bitn          <= next_bitn;
      shreg         <= next_shreg;
      txsh          <= next_txsh;
      tx_byte       <= next_tx_byte;
      addr_ph       <= next_addr_ph;
      is_rd         <= next_is_rd;
      in_wr         <= next_in_wr;
      ack           <= next_ack;
      mack          <= next_mack;
      wr_cnt        <= next_wr_cnt;
      wr_tot        <= next_wr_tot;
      wr_exec       <= next_wr_exec;
      cmd_hold      <= next_cmd_hold;
      hi_hold       <= next_hi_hold;
      last_cmd      <= next_last_cmd;
      req_cmd       <= next_req_cmd;
      readback_mode <= next_mode;
      consumed      <= next_consumed;
      byte_idx      <= next_byte_idx;
      sda_oe_n      <= next_sda_oe_n;
      sda_out       <= 1'b0;
    end
  end

  // ****************************************
  // Written bytes towards the command decoder
  // ****************************************
  logic       fifo_valid;
  logic       fifo_take;
  logic [7:0] fifo_data;
  logic       next_wr_valid;
  logic [7:0] next_wr_data;

  dacrb_fifo #(
    .WIDTH (dacrb_pkg::BYTE_W),
    .DEPTH (dacrb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (shreg),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  always_comb begin
    fifo_take     = !wr_valid || wr_ready;
    next_wr_valid = fifo_take ? fifo_valid : wr_valid;
    next_wr_data  = (fifo_take && fifo_valid) ? fifo_data : wr_data;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_data  <= '0;
    end else begin
      wr_valid <= next_wr_valid;
      wr_data  <= next_wr_data;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_rd_addr_acked;
    state == dacrb_pkg::ST_ACKW && is_rd && fall_ev;
  endsequence

  chk_first_byte_out: assert property (
    s_rd_addr_acked |=> state == dacrb_pkg::ST_TX &&
      tx_byte == ((readback_mode == dacrb_pkg::MODE_VERIF) ?
        (consumed ? dacrb_pkg::FILL_BYTE : last_cmd[23:16]) : rd_word[15:8])
      && sda_oe_n == tx_byte[7])
    else $error("first read byte wrong");
  chk_fill_ones: assert property (
    state == dacrb_pkg::ST_MACK && fall_ev && mack &&
    byte_idx == dacrb_pkg::IDX_SAT |=> tx_byte == dacrb_pkg::FILL_BYTE)
    else $error("extra byte not all ones");
  chk_stage_sel_a: assert property (
    req_cmd[7:4] == dacrb_pkg::NIB_STAGED &&
    req_cmd[3:0] > dacrb_pkg::SEL_LAST_CH |->
      rd_word[15:4] == staged_code_value[0])
    else $error("all-channel staged read not channel A");
  chk_power_bits: assert property (
    req_cmd[7:4] == dacrb_pkg::NIB_POWER |-> rd_word[15:4] == '0 &&
      rd_word[0] == chan_a_powerdown_flag &&
      rd_word[3] == chan_d_powerdown_flag)
    else $error("power readback format wrong");
  chk_ident_fmt: assert property (
    req_cmd[7:4] > dacrb_pkg::NIB_POWER &&
    !(req_cmd >= dacrb_pkg::CMD_ALL_STAGED &&
      req_cmd <= dacrb_pkg::CMD_ALL_ACT_HI) |->
      rd_word[15:8] == IDENT_BYTE && rd_word[7:5] == '0)
    else $error("identity readback format wrong");
  chk_all_sel_a: assert property (
    req_cmd >= dacrb_pkg::CMD_ALL_STAGED &&
    req_cmd <= dacrb_pkg::CMD_ALL_ACT_HI |->
      rd_word[15:4] == ((req_cmd == dacrb_pkg::CMD_ALL_STAGED) ?
        staged_code_value[dacrb_pkg::CH_A] :
        active_output_value[dacrb_pkg::CH_A]) && rd_word[3:0] == '0)
    else $error("all-channel command not channel A");
  chk_left_align: assert property (
    req_cmd[7:4] <= dacrb_pkg::NIB_LOAD_LAST |-> rd_word[3:0] == '0)
    else $error("channel value not left aligned");
  chk_other_dev: assert property (
    state == dacrb_pkg::ST_IGN && !frame_end |=>
      $stable(readback_mode) && $stable(last_cmd) && $stable(req_cmd))
    else $error("foreign transfer changed readback state");
  chk_verif_select: assert property (
    frame_end && in_wr && wr_exec |=>
      readback_mode == dacrb_pkg::MODE_VERIF && !consumed)
    else $error("executed write did not select verification");
  chk_verif_once: assert property (
    frame_end && is_rd && readback_mode == dacrb_pkg::MODE_VERIF |=>
      consumed [*2])
    else $error("verification read not consumed");
  chk_stop_ends: assert property (
    stop_det |=> state == dacrb_pkg::ST_IDLE && sda_oe_n ##1 byte_idx ==
      $past(byte_idx, 2) || state != dacrb_pkg::ST_IDLE)
    else $error("stop did not end transfer");
  chk_addr_ack: assert property (
    state == dacrb_pkg::ST_RX && addr_ph && fall_ev &&
    bitn == dacrb_pkg::BIT_LAST &&
    shreg[7:1] == {dacrb_pkg::ADDR_FIXED, strap_s2} |=>
      state == dacrb_pkg::ST_ACKW && !sda_oe_n)
    else $error("own address not acknowledged");

endmodule // dacrb_engine

// ### testbench/dacrb_i2c_mst.sv
// I2C bus master model: drives SCL and pulls SDA low, never high.
// Assumes the bench resolves SDA with a pull-up and the device's enable.
`timescale 1ns/100ps
module dacrb_i2c_mst (
  output logic scl,
  output logic pull,
  input  wire  sda
);
  // SCL quarter period, a multiple of 64 ns; SCL stands high between frames
  localparam int Q = 832;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic bit_x(input logic o, output logic i);
    pull = !o;
    #Q scl = 1'b1;
    #Q i = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Start and repeated start
  task automatic start;
    pull = 1'b0;
    #Q scl = 1'b1;
    #Q pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop;
    pull = 1'b1;
    #Q scl = 1'b1;
    #Q pull = 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(b[i], ack);
    bit_x(1'b1, ack);
  endtask
  // Master acknowledges with 0, ends with 1 before the stop
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(nack, x);
  endtask
endmodule // dacrb_i2c_mst

// ### testbench/tb.sv
// Bench of the readback engine, driven by the I2C master model.
// Assumes design ports as declared in dacrb_engine.
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
  localparam logic [2:0] RV = 3'h5;  // Arbitrary revision value
  localparam logic [6:0] SA = 7'h19;
  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic             wr_ready = 1'b1;
  logic [3:0]       pd = 4'hd;
  logic [1:0]       rf = 2'h2;
  logic [3:0][11:0] stg = {12'habc, 12'h789, 12'h456, 12'h123};
  logic [3:0][11:0] act = {12'hcba, 12'h987, 12'h654, 12'h321};
  logic             scl, pull, sda_out, sda_oe_n, wr_valid, rb_mode;
  logic [7:0]       wr_data, last_wr;
  wire              sda = !(pull || !sda_oe_n);
  int               num_errors = 0;
  int               n_checks = 0;
  initial forever #50 core_clk = !core_clk;
  always @(posedge core_clk) if (wr_valid && wr_ready) last_wr <= wr_data;
  dacrb_i2c_mst mst (.scl(scl), .pull(pull), .sda(sda));
  dacrb_engine #(.IDENT_BYTE(ID), .REVISION(RV)) dut (
    .core_clk(core_clk), .rst(rst), .scl_clk(scl), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_strap_low(2'h1), .address_strap_high(2'h2),
    .staged_code_value(stg), .active_output_value(act),
    .chan_a_powerdown_flag(pd[0]), .chan_b_powerdown_flag(pd[1]),
    .chan_c_powerdown_flag(pd[2]), .chan_d_powerdown_flag(pd[3]),
    .reference_mode_field(rf), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .readback_mode(rb_mode));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(output logic [31:0] d);
    logic a;
    mst.start();
    mst.wbyte({SA, 1'b1}, a);
    mst.rbyte(1'b0, d[31:24]);
    mst.rbyte(1'b0, d[23:16]);
    mst.rbyte(1'b0, d[15:8]);
    mst.rbyte(1'b1, d[7:0]);
    mst.stop();
  endtask
  task automatic comb(input logic [7:0] cmd, input logic [15:0] exp);
    logic        a;
    logic [31:0] d;
    mst.start();
    mst.wbyte({SA, 1'b0}, a);
    mst.wbyte(cmd, a);
    rd(d);
    chk(d, {exp, 16'hffff});
  endtask
  initial begin
    #8000000;
    num_errors++;
    results();
  end
  initial begin
    logic [31:0] d;
    logic        a;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 5; i++)
      comb({4'h0, i == 4 ? 4'hf : 4'(i)}, {stg[i % 4], 4'h0});
    for (int n = 1; n < 4; n++)
      comb({4'(n), 4'(n)}, {act[n], 4'h0});
    comb(8'h18, {act[0], 4'h0});
    comb(8'h80, {stg[0], 4'h0});
    comb(8'h82, {act[0], 4'h0});
    comb(8'h40, {12'h000, pd});
    comb(8'h9c, {ID, 3'h0, RV, rf});
    chk(rb_mode, 0);
    mst.start();
    mst.wbyte({SA, 1'b0}, a);
    chk(a, 0);
    for (int k = 5; k >= 0; k--) mst.wbyte(8'(48'h312ab0326cd0 >> 8 * k), a);
    mst.stop();
    chk(last_wr, 8'hd0);
    mst.start();
    mst.wbyte(8'ha0, a);
    chk(a, 1);
    mst.wbyte(8'h11, a);
    mst.stop();
    chk(rb_mode, 1);
    rd(d);
    chk(d, 32'h326cd0ff);
    rd(d);
    chk(d, 32'hffffffff);
    comb(8'h5f, {ID, 3'h0, RV, rf});
    mst.start();
    mst.wbyte({SA, 1'b1}, a);
    repeat (4) mst.bit_x(1'b1, a);
    mst.stop();
    rd(d);
    chk(d, {ID, 3'h0, RV, rf, 16'hffff});
    chk(rb_mode, 0);
    chk(sda_out, 0);
    results();
  end
endmodule // tb
